// [shared/uic_pkg.sv]
// constants, types and trigger tables of the channel interrupt and fifo-control block
// ============================================================
// Summary of operation
// R1: mask bit 5 enables Xoff receive interrupt
// R2: mask bit 6 enables flow output toggle interrupt
// R3: mask bit 7 enables flow input toggle interrupt
// R4: status shows highest pending; held until serviced
// R5: codes levels 1-4: 06, 04, 0C, 02
// R6: codes levels 5-7: 00, 10, 20; none 01
// R7: line error raises; line status read clears
// R8: receive trigger reached raises; below trigger clears
// R9: timeout after 4 chars+12 bits; empty clears
// R10: transmit ready follows holding/shift empty; status read
// R11: modem delta raises; modem status read clears
// R12: Xon/Xoff/special raise level 6; defined clears
// R13: flow pin rising raises level 7; modem read
// R14: wake indication on sleep exit; global read clears
// R15: status bit 0 low when pending, reset 1
// R16: status bits 5:4 only with enhanced enable
// R17: status bits 7:6 mirror fifo enable
// R18: software writes fifo bit 0 with others
// R19: fifo reset bits pulse pointer reset, self-clear
// R20: block mode bit stored without effect
// R21: transmit trigger select, empty when not refilled
// R22: one trigger table shared by both directions
// R23: enhanced enable gates extended mask/status/control bits
// R24: modem control bit 2 selects flow pin pair
// R25: irq output whenever enabled source pending
package uic_pkg;
    // ============================================================
    // register map (index on the 4-bit address port)
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CTRL = 4'h2;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // interrupt mask fields
    localparam int IM_RX = 0;
    localparam int IM_TX = 1;
    localparam int IM_LS = 2;
    localparam int IM_MS = 3;
    localparam int IM_XOFF = 5;
    localparam int IM_FOUT = 6;
    localparam int IM_FIN = 7;
    // fifo control fields
    localparam int FC_EN = 0;
    localparam int FC_RXRST = 1;
    localparam int FC_TXRST = 2;
    localparam int FC_BLK = 3;
    localparam int FC_TXT_LO = 4;
    localparam int FC_TXT_HI = 5;
    localparam int FC_RXT_LO = 6;
    localparam int FC_RXT_HI = 7;
    // ============================================================
    // status codes
    localparam logic [5:0] CODE_LS = 6'h06;
    localparam logic [5:0] CODE_RX = 6'h04;
    localparam logic [5:0] CODE_TO = 6'h0C;
    localparam logic [5:0] CODE_TX = 6'h02;
    localparam logic [5:0] CODE_MS = 6'h00;
    localparam logic [5:0] CODE_XC = 6'h10;
    localparam logic [5:0] CODE_FC = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    // ============================================================
    // receive timeout: character times plus bit times
    localparam logic [7:0] TO_CHARS = 8'h04;
    localparam logic [7:0] TO_BITS = 8'h0C;
    // default trigger level of both directions
    localparam logic [6:0] TRIG_RESET = 7'h01;
    localparam int LVW = 7;
    typedef enum logic [2:0] {LV_NONE, LV_LS, LV_RX, LV_TO, LV_TX, LV_MS, LV_XC, LV_FC} uic_lvl_t;
    function automatic logic [5:0] lvl_code(input uic_lvl_t l);
        unique case (l)
            LV_LS: lvl_code = CODE_LS;
            LV_RX: lvl_code = CODE_RX;
            LV_TO: lvl_code = CODE_TO;
            LV_TX: lvl_code = CODE_TX;
            LV_MS: lvl_code = CODE_MS;
            LV_XC: lvl_code = CODE_XC;
            LV_FC: lvl_code = CODE_FC;
            LV_NONE: lvl_code = CODE_NONE;
        endcase
    endfunction
    // table 3 is the programmable one; its level comes in as prog
    function automatic logic [LVW-1:0] trig(input logic [1:0] tbl, input logic [1:0] sel,
                                            input logic tx, input logic [LVW-1:0] prog);
        logic [LVW-1:0] a [4];
        logic [LVW-1:0] b [4];
        logic [LVW-1:0] c [4];
        a = '{7'h01, 7'h04, 7'h08, 7'h0E};
        if (tx) begin
            b = '{7'h10, 7'h08, 7'h18, 7'h1E};
            c = '{7'h08, 7'h10, 7'h20, 7'h38};
        end else begin
            b = '{7'h08, 7'h10, 7'h18, 7'h1C};
            c = '{7'h08, 7'h10, 7'h38, 7'h3C};
        end
        unique case (tbl)
            2'h0: trig = tx ? a[0] : a[sel];
            2'h1: trig = b[sel];
            2'h2: trig = c[sel];
            2'h3: trig = prog;
        endcase
    endfunction
endpackage

// [core/uic_sync3.sv]
// three-stage synchroniser for pins from outside the clock domain
module uic_sync3 (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } uic_sync_t;
    uic_sync_t s_q;
    uic_sync_t s_d;
    // ============================================================
    // output only changes once stages two and three agree
    always_comb begin
        s_d = s_q;
        s_d.s1 = d_i;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.q = s_q.s3;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
    assign q_o = s_q.q;
endmodule // uic_sync3

// [core/uic_core.sv]
// per-channel interrupt priority encoder and fifo control register
//
// Decided for this implementation: strobed register access and the placing of the registers.
module uic_core (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic enh_en_i,
    input wire logic auto_in_en_i,
    input wire logic auto_out_en_i,
    input wire logic pin_sel_dtr_i,
    input wire logic rs485_en_i,
    input wire logic [1:0] table_sel_i,
    input wire logic [6:0] rx_prog_trig_i,
    input wire logic [6:0] tx_prog_trig_i,
    input wire logic [3:0] line_err_i,
    input wire logic line_status_rd_i,
    input wire logic [3:0] modem_delta_i,
    input wire logic modem_status_rd_i,
    input wire logic global_irq_rd_i,
    input wire logic rx_data_rd_i,
    input wire logic rx_char_i,
    input wire logic [6:0] rx_level_i,
    input wire logic [6:0] tx_level_i,
    input wire logic hold_empty_i,
    input wire logic tx_all_empty_i,
    input wire logic bit_tick_i,
    input wire logic [3:0] char_bits_i,
    input wire logic xonoff_det_i,
    input wire logic special_det_i,
    input wire logic cts_pin_i,
    input wire logic dsr_pin_i,
    input wire logic rts_out_i,
    input wire logic dtr_out_i,
    input wire logic sleep_exit_i,
    output logic irq_o,
    output logic wake_o,
    output logic fifo_en_o,
    output logic rx_fifo_rst_o,
    output logic tx_fifo_rst_o,
    output logic block_mode_o,
    output logic [6:0] rx_trig_o,
    output logic [6:0] tx_trig_o
);
    typedef struct packed {
        logic [7:0] mask;
        logic fifo_en;
        logic blk;
        logic [1:0] txsel;
        logic [1:0] rxsel;
        logic [1:0] tbl;
        logic [1:0] tbl_seen;
        logic rxrst;
        logic txrst;
        logic [7:0] rdata;
        uic_pkg::uic_lvl_t cur;
        logic ls;
        logic ms;
        logic tx;
        logic to;
        logic xc;
        logic sp;
        logic fc;
        logic wake;
        logic irq;
        logic err_d;
        logic ms_d;
        logic txc_d;
        logic fill;
        logic fin_d;
        logic fout_d;
        logic [7:0] tcnt;
        logic [6:0] rxt;
        logic [6:0] txt;
    } uic_state_t;
    uic_state_t s_q;
    uic_state_t s_d;
    logic cts_s;
    logic dsr_s;
    // ============================================================
    // pin synchronisers
    uic_sync3 u_cts (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .d_i(cts_pin_i),
        .q_o(cts_s)
    );
    uic_sync3 u_dsr (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .d_i(dsr_pin_i),
        .q_o(dsr_s)
    );
    // ============================================================
    // source conditions
    logic wr_fc;
    logic rd_st;
    logic fin;
    logic fout;
    logic rx_lvl;
    logic txc;
    logic to_run;
    logic [7:0] to_lim;
    logic [7:0] emask;
    logic [7:0] pend;
    uic_pkg::uic_lvl_t top;
    logic cur_live;
    always_comb begin
        wr_fc = wr_i && addr_i == uic_pkg::ADDR_FIFO_CTRL;
        rd_st = rd_i && addr_i == uic_pkg::ADDR_STATUS;
        fin = pin_sel_dtr_i ? dsr_s : cts_s; // R24
        fout = pin_sel_dtr_i ? dtr_out_i : rts_out_i; // R24
        rx_lvl = s_q.fifo_en ? rx_level_i >= s_q.rxt : rx_level_i != '0; // R8
        // not refilled past the trigger: wait for empty instead
        txc = rs485_en_i ? tx_all_empty_i : // R10
            !s_q.fifo_en ? hold_empty_i :
            s_q.fill ? tx_level_i < s_q.txt : tx_level_i == '0; // R21
        to_run = s_q.fifo_en && rx_level_i != '0 && !rx_lvl;
        to_lim = 8'(uic_pkg::TO_CHARS * char_bits_i) + uic_pkg::TO_BITS; // R9
        emask = s_q.mask;
        emask[7:5] = enh_en_i ? s_q.mask[7:5] : 3'h0; // R1 R2 R3 R23
        pend = '0;
        pend[uic_pkg::LV_LS] = s_q.ls && emask[uic_pkg::IM_LS];
        pend[uic_pkg::LV_RX] = rx_lvl && emask[uic_pkg::IM_RX];
        pend[uic_pkg::LV_TO] = s_q.to && emask[uic_pkg::IM_RX];
        pend[uic_pkg::LV_TX] = s_q.tx && emask[uic_pkg::IM_TX];
        pend[uic_pkg::LV_MS] = s_q.ms && emask[uic_pkg::IM_MS];
        pend[uic_pkg::LV_XC] = (s_q.xc || s_q.sp) && emask[uic_pkg::IM_XOFF] && enh_en_i; // R16
        pend[uic_pkg::LV_FC] = s_q.fc && (emask[uic_pkg::IM_FIN] || emask[uic_pkg::IM_FOUT]) && enh_en_i; // R16
        top = uic_pkg::LV_NONE;
        for (int i = 7; i >= 1; i--) begin
            if (pend[i]) begin
                top = uic_pkg::uic_lvl_t'(i);
            end
        end
        cur_live = s_q.cur != uic_pkg::LV_NONE && pend[s_q.cur];
    end
    // ============================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rxrst = 1'b0;
        s_d.txrst = 1'b0;
        s_d.rdata = '0;
        if (wr_i && addr_i == uic_pkg::ADDR_MASK) begin
            s_d.mask = wdata_i;
            if (!enh_en_i) begin
                s_d.mask[7:5] = s_q.mask[7:5]; // R23
            end
        end
        // bits beyond bit 0 only land when bit 0 is written set
        if (wr_fc) begin
            s_d.fifo_en = wdata_i[uic_pkg::FC_EN]; // R18
            if (wdata_i[uic_pkg::FC_EN]) begin
                s_d.rxrst = wdata_i[uic_pkg::FC_RXRST]; // R19
                s_d.txrst = wdata_i[uic_pkg::FC_TXRST]; // R19
                s_d.blk = wdata_i[uic_pkg::FC_BLK]; // R20
                s_d.rxsel = wdata_i[uic_pkg::FC_RXT_HI:uic_pkg::FC_RXT_LO];
                if (enh_en_i) begin
                    s_d.txsel = wdata_i[uic_pkg::FC_TXT_HI:uic_pkg::FC_TXT_LO]; // R21 R23
                end
            end
        end
        // one table for both sides, the latest selection wins
        s_d.tbl_seen = table_sel_i;
        if (table_sel_i != s_q.tbl_seen) begin
            s_d.tbl = table_sel_i; // R22
        end
        s_d.rxt = uic_pkg::trig(s_q.tbl, s_q.rxsel, 1'b0, rx_prog_trig_i); // R22
        s_d.txt = uic_pkg::trig(s_q.tbl, s_q.txsel, 1'b1, tx_prog_trig_i); // R21 R22
        // line status: rising edge of the OR of all error bits, cleared by its read
        s_d.err_d = |line_err_i;
        if (line_status_rd_i) begin
            s_d.ls = 1'b0; // R7
        end
        if (|line_err_i && !s_q.err_d) begin
            s_d.ls = 1'b1; // R7
        end
        s_d.ms_d = |modem_delta_i;
        s_d.fin_d = fin;
        s_d.fout_d = fout;
        if (modem_status_rd_i) begin
            s_d.ms = 1'b0; // R11
            s_d.fc = 1'b0; // R13
        end
        if (|modem_delta_i && !s_q.ms_d) begin
            s_d.ms = 1'b1; // R11
        end
        if ((auto_in_en_i && fin && !s_q.fin_d) || (auto_out_en_i && fout && !s_q.fout_d)) begin
            s_d.fc = 1'b1; // R13
        end
        // transmit ready
        s_d.txc_d = txc;
        if (tx_level_i > s_q.txt) begin
            s_d.fill = 1'b1; // R21
        end else if (txc && !s_q.txc_d) begin
            s_d.fill = 1'b0;
        end
        if (rd_st && s_q.cur == uic_pkg::LV_TX) begin
            s_d.tx = 1'b0; // R10
        end
        if (txc && !s_q.txc_d) begin
            s_d.tx = 1'b1; // R10
        end
        // receive timeout counts bit times since the last receive activity
        if (!to_run || rx_char_i || rx_data_rd_i) begin
            s_d.tcnt = '0;
        end else if (bit_tick_i && s_q.tcnt != to_lim) begin
            s_d.tcnt = s_q.tcnt + 8'h01;
        end
        if (rx_level_i == '0) begin
            s_d.to = 1'b0; // R9
        end
        if (to_run && s_q.tcnt == to_lim) begin
            s_d.to = 1'b1; // R9
        end
        // level 6 sources
        if (rd_st && s_q.cur == uic_pkg::LV_XC) begin
            s_d.xc = 1'b0; // R12
            s_d.sp = 1'b0; // R12
        end
        if (rx_char_i) begin
            s_d.sp = 1'b0; // R12
        end
        if (xonoff_det_i) begin
            s_d.xc = 1'b1; // R12
        end
        if (special_det_i) begin
            s_d.sp = 1'b1; // R12
        end
        if (global_irq_rd_i) begin
            s_d.wake = 1'b0; // R14
        end
        if (sleep_exit_i) begin
            s_d.wake = 1'b1; // R14
        end
        // a presented source keeps the status until it is serviced
        s_d.cur = cur_live ? s_q.cur : top; // R4
        s_d.irq = s_d.cur != uic_pkg::LV_NONE; // R25
        if (rd_st) begin
            s_d.rdata = {s_q.fifo_en, s_q.fifo_en, uic_pkg::lvl_code(s_q.cur)}; // R5 R6 R15 R17
        end else if (rd_i && addr_i == uic_pkg::ADDR_MASK) begin
            s_d.rdata = s_q.mask;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.mask <= uic_pkg::MASK_RESET; // R1 R2 R3
            s_q.cur <= uic_pkg::LV_NONE; // R15
            s_q.rxt <= uic_pkg::TRIG_RESET;
            s_q.txt <= uic_pkg::TRIG_RESET;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
    // ============================================================
    // outputs
    assign rdata_o = s_q.rdata;
    assign irq_o = s_q.irq;
    assign wake_o = s_q.wake;
    assign fifo_en_o = s_q.fifo_en;
    assign rx_fifo_rst_o = s_q.rxrst;
    assign tx_fifo_rst_o = s_q.txrst;
    assign block_mode_o = s_q.blk;
    assign rx_trig_o = s_q.rxt;
    assign tx_trig_o = s_q.txt;
    // ============================================================
    // checks
    sequence st_read;
        rd_st && ce_i;
    endsequence
    sequence fc_bad_write;
        wr_fc && ce_i && !wdata_i[uic_pkg::FC_EN];
    endsequence
    a_status_fifo_bits: assert property (@(posedge clk_i) disable iff (srst_i) // R17
        st_read |=> rdata_o[7:6] == {2{$past(fifo_en_o)}}) else $error("fifo bits wrong");
    a_status_none_code: assert property (@(posedge clk_i) disable iff (srst_i) // R15
        st_read ##0 !irq_o |=> rdata_o[5:0] == uic_pkg::CODE_NONE) else $error("idle code wrong");
    a_irq_from_pend: assert property (@(posedge clk_i) disable iff (srst_i) // R25
        ce_i && (top != uic_pkg::LV_NONE) |=> irq_o) else $error("irq not raised");
    a_fifo_rst_pulse: assert property (@(posedge clk_i) disable iff (srst_i) // R19
        rx_fifo_rst_o && ce_i |=> !rx_fifo_rst_o) else $error("reset bit not self clearing");
    a_fc_ignore_bits: assert property (@(posedge clk_i) disable iff (srst_i) // R18
        fc_bad_write |=> !fifo_en_o && !rx_fifo_rst_o && !tx_fifo_rst_o) else $error("bits taken without enable");
    a_hold_current: assert property (@(posedge clk_i) disable iff (srst_i) // R4
        ce_i && cur_live |=> $stable(s_q.cur)) else $error("current source replaced");
    a_line_set: assert property (@(posedge clk_i) disable iff (srst_i) // R7
        ce_i && |line_err_i && !s_q.err_d |=> s_q.ls) else $error("line error lost");
    a_wake_set: assert property (@(posedge clk_i) disable iff (srst_i) // R14
        ce_i && sleep_exit_i |=> wake_o) else $error("wake lost");
    a_ext_masked: assert property (@(posedge clk_i) disable iff (srst_i) // R16
        !enh_en_i |-> !pend[uic_pkg::LV_XC] && !pend[uic_pkg::LV_FC]) else $error("extended source leaked");
    a_to_clears: assert property (@(posedge clk_i) disable iff (srst_i) // R9
        ce_i && rx_level_i == '0 && !to_run |=> !s_q.to) else $error("timeout not cleared");
endmodule // uic_core

// [verification/uic_line_model.sv]
// line-side partner: bit-time ticks and the asynchronous flow-control input pins
module uic_line_model #(
    parameter int TICK_DIV = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sel_dtr_i,
    input wire logic raise_i,
    output logic bit_tick_o,
    output logic cts_pin_o,
    output logic dsr_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // ============================================================
    // bit clock
    always_ff @(posedge clk_i) begin
        if (srst_i || cnt_q == TICK_DIV - 1) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign bit_tick_o = (cnt_q == TICK_DIV - 1);
    // ============================================================
    // pins move between clock edges, as a real modem would; only the selected pair is raised
    assign #7 cts_pin_o = raise_i & ~sel_dtr_i;
    assign #7 dsr_pin_o = raise_i & sel_dtr_i;
endmodule // uic_line_model

// [verification/uic_core_tb.sv]
// self-checking testbench of the channel interrupt and fifo-control block
module uic_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int S_LINE = 0, S_MODEM = 1, S_GLB = 2, S_XON = 3, S_SPC = 4, S_CHR = 5, S_SLP = 6, S_RXD = 7;
    logic clk_i, srst_i, ce_i, wr_i, rd_i, enh_en_i, auto_in_en_i, auto_out_en_i, pin_sel_dtr_i, rs485_en_i;
    logic line_status_rd_i, modem_status_rd_i, global_irq_rd_i, rx_data_rd_i, rx_char_i, hold_empty_i;
    logic tx_all_empty_i, xonoff_det_i, special_det_i, rts_out_i, dtr_out_i, sleep_exit_i, raise;
    logic bit_tick, cts_pin, dsr_pin, irq_o, wake_o, fifo_en_o, rx_fifo_rst_o, tx_fifo_rst_o, block_mode_o;
    logic [1:0] table_sel_i;
    logic [3:0] addr_i, line_err_i, modem_delta_i, char_bits_i;
    logic [6:0] rx_prog_trig_i, tx_prog_trig_i, rx_level_i, tx_level_i, rx_trig_o, tx_trig_o;
    logic [7:0] wdata_i, rdata_o;
    int checked = 0;
    int mismatches = 0;
    int cycles = 0;

    uic_core uic_core_i (.clk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .enh_en_i,
        .auto_in_en_i, .auto_out_en_i, .pin_sel_dtr_i, .rs485_en_i, .table_sel_i, .rx_prog_trig_i,
        .tx_prog_trig_i, .line_err_i, .line_status_rd_i, .modem_delta_i, .modem_status_rd_i, .global_irq_rd_i,
        .rx_data_rd_i, .rx_char_i, .rx_level_i, .tx_level_i, .hold_empty_i, .tx_all_empty_i,
        .bit_tick_i(bit_tick), .char_bits_i, .xonoff_det_i, .special_det_i, .cts_pin_i(cts_pin),
        .dsr_pin_i(dsr_pin), .rts_out_i, .dtr_out_i, .sleep_exit_i, .irq_o, .wake_o, .fifo_en_o,
        .rx_fifo_rst_o, .tx_fifo_rst_o, .block_mode_o, .rx_trig_o, .tx_trig_o);
    uic_line_model uic_line_model_i (.clk_i(clk_i), .srst_i(srst_i), .sel_dtr_i(pin_sel_dtr_i),
        .raise_i(raise), .bit_tick_o(bit_tick), .cts_pin_o(cts_pin), .dsr_pin_o(dsr_pin));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ============================================================
    // tasks
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hang costs far more cycles than the whole sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            $display("CHECK FAILED run length expected below 4000 cycles seen %0d", cycles);
            end_sim();
        end
    end
    task automatic chk_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk_byte(what, rdata_o, exp);
    endtask
    task automatic strobe(input int k);
        @(posedge clk_i);
        case (k)
            S_LINE: line_status_rd_i <= 1'b1;
            S_MODEM: modem_status_rd_i <= 1'b1;
            S_GLB: global_irq_rd_i <= 1'b1;
            S_XON: xonoff_det_i <= 1'b1;
            S_SPC: special_det_i <= 1'b1;
            S_CHR: rx_char_i <= 1'b1;
            S_SLP: sleep_exit_i <= 1'b1;
            default: rx_data_rd_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {line_status_rd_i, modem_status_rd_i, global_irq_rd_i, xonoff_det_i} <= 4'h0;
        {special_det_i, rx_char_i, sleep_exit_i, rx_data_rd_i} <= 4'h0;
    endtask
    // ============================================================
    // sequence
    initial begin
        {ce_i, srst_i} = 2'h3;
        {wr_i, rd_i, enh_en_i, auto_in_en_i, auto_out_en_i, pin_sel_dtr_i, rs485_en_i, raise} = 8'h00;
        {line_status_rd_i, modem_status_rd_i, global_irq_rd_i, rx_data_rd_i, rx_char_i} = 5'h00;
        {hold_empty_i, tx_all_empty_i, xonoff_det_i, special_det_i, rts_out_i, dtr_out_i, sleep_exit_i} = 7'h00;
        {table_sel_i, addr_i, line_err_i, modem_delta_i, wdata_i} = '0;
        {rx_prog_trig_i, tx_prog_trig_i, rx_level_i, tx_level_i} = {7'h05, 7'h09, 7'h00, 7'h03};
        char_bits_i = 4'h8;
        cyc(8);
        srst_i <= 1'b0;
        rd_reg("status after reset", uic_pkg::ADDR_STATUS, 8'h01);
        rd_reg("mask after reset", uic_pkg::ADDR_MASK, uic_pkg::MASK_RESET);
        chk_flag("irq after reset", 1'b0, irq_o);
        chk_byte("rx trigger after reset", {1'b0, rx_trig_o}, 8'h01);
        $display("test reset done");
        wr_reg(uic_pkg::ADDR_MASK, 8'hEC);
        rd_reg("mask without enhanced", uic_pkg::ADDR_MASK, 8'h0C);
        enh_en_i <= 1'b1;
        wr_reg(uic_pkg::ADDR_MASK, 8'hEC);
        rd_reg("mask with enhanced", uic_pkg::ADDR_MASK, 8'hEC);
        $display("test mask done");
        line_err_i <= 4'h2;
        modem_delta_i <= 4'h1;
        cyc(4);
        chk_flag("irq line and modem", 1'b1, irq_o);
        rd_reg("status line error", uic_pkg::ADDR_STATUS, 8'h06);
        strobe(S_LINE);
        line_err_i <= 4'h0;
        cyc(3);
        rd_reg("status modem", uic_pkg::ADDR_STATUS, 8'h00);
        strobe(S_MODEM);
        modem_delta_i <= 4'h0;
        cyc(3);
        rd_reg("status cleared", uic_pkg::ADDR_STATUS, 8'h01);
        chk_flag("irq cleared", 1'b0, irq_o);
        $display("test priority done");
        wr_reg(uic_pkg::ADDR_MASK, 8'hEE);
        hold_empty_i <= 1'b1;
        cyc(4);
        rd_reg("status tx ready", uic_pkg::ADDR_STATUS, 8'h02);
        rd_reg("status tx after read", uic_pkg::ADDR_STATUS, 8'h01);
        // shift side still busy first, so the ready condition rises afresh
        rs485_en_i <= 1'b1;
        cyc(2);
        tx_all_empty_i <= 1'b1;
        cyc(4);
        rd_reg("status tx half duplex", uic_pkg::ADDR_STATUS, 8'h02);
        rd_reg("status tx hd after read", uic_pkg::ADDR_STATUS, 8'h01);
        {rs485_en_i, tx_all_empty_i, hold_empty_i} <= 3'h0;
        wr_reg(uic_pkg::ADDR_MASK, 8'hEC);
        $display("test transmit ready done");
        strobe(S_XON);
        cyc(3);
        rd_reg("status xon xoff", uic_pkg::ADDR_STATUS, 8'h10);
        rd_reg("status xon after read", uic_pkg::ADDR_STATUS, 8'h01);
        strobe(S_SPC);
        cyc(3);
        chk_flag("irq special", 1'b1, irq_o);
        strobe(S_CHR);
        cyc(3);
        rd_reg("special cleared by char", uic_pkg::ADDR_STATUS, 8'h01);
        enh_en_i <= 1'b0;
        strobe(S_XON);
        cyc(3);
        rd_reg("level 6 without enhanced", uic_pkg::ADDR_STATUS, 8'h01);
        enh_en_i <= 1'b1;
        rd_reg("level 6 with enhanced", uic_pkg::ADDR_STATUS, 8'h10);
        auto_in_en_i <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            pin_sel_dtr_i <= p[0];
            cyc(8);
            raise <= 1'b1;
            cyc(8);
            rd_reg("status flow input", uic_pkg::ADDR_STATUS, 8'h20);
            strobe(S_MODEM);
            raise <= 1'b0;
            cyc(3);
            rd_reg("flow input cleared", uic_pkg::ADDR_STATUS, 8'h01);
        end
        {auto_in_en_i, auto_out_en_i} <= 2'h1;
        dtr_out_i <= 1'b1;
        cyc(4);
        rd_reg("status flow output", uic_pkg::ADDR_STATUS, 8'h20);
        strobe(S_MODEM);
        {auto_out_en_i, dtr_out_i, pin_sel_dtr_i} <= 3'h0;
        cyc(3);
        rd_reg("flow output cleared", uic_pkg::ADDR_STATUS, 8'h01);
        $display("test special and flow done");
        strobe(S_SLP);
        cyc(3);
        chk_flag("wake set", 1'b1, wake_o);
        strobe(S_GLB);
        cyc(2);
        chk_flag("wake cleared", 1'b0, wake_o);
        $display("test wake done");
        wr_reg(uic_pkg::ADDR_FIFO_CTRL, 8'h07);
        @(negedge clk_i);
        chk_byte("fifo en and resets", {5'h00, fifo_en_o, rx_fifo_rst_o, tx_fifo_rst_o}, 8'h07);
        @(negedge clk_i);
        chk_byte("reset pulses end", {6'h00, rx_fifo_rst_o, tx_fifo_rst_o}, 8'h00);
        rd_reg("status fifo on", uic_pkg::ADDR_STATUS, 8'hC1);
        wr_reg(uic_pkg::ADDR_FIFO_CTRL, 8'h06);
        @(negedge clk_i);
        chk_byte("write with bit 0 low", {5'h00, fifo_en_o, rx_fifo_rst_o, tx_fifo_rst_o}, 8'h00);
        rd_reg("status fifo off", uic_pkg::ADDR_STATUS, 8'h01);
        wr_reg(uic_pkg::ADDR_FIFO_CTRL, 8'h09);
        @(negedge clk_i);
        chk_flag("block mode stored", 1'b1, block_mode_o);
        chk_flag("fifo on again", 1'b1, fifo_en_o);
        $display("test fifo control done");
        wr_reg(uic_pkg::ADDR_MASK, 8'hED);
        rx_level_i <= 7'h01;
        cyc(4);
        rd_reg("status rx trigger", uic_pkg::ADDR_STATUS, 8'hC4);
        strobe(S_RXD);
        rx_level_i <= 7'h00;
        cyc(3);
        rd_reg("status rx drained", uic_pkg::ADDR_STATUS, 8'hC1);
        // trigger 4 with one byte waiting: 4*8+12 bit ticks of 4 cycles each
        wr_reg(uic_pkg::ADDR_FIFO_CTRL, 8'h41);
        rx_level_i <= 7'h01;
        cyc(200);
        rd_reg("status rx timeout", uic_pkg::ADDR_STATUS, 8'hCC);
        rx_level_i <= 7'h00;
        cyc(3);
        rd_reg("timeout cleared", uic_pkg::ADDR_STATUS, 8'hC1);
        table_sel_i <= 2'h1;
        cyc(3);
        chk_byte("shared table rx", {1'b0, rx_trig_o}, 8'h10);
        chk_byte("shared table tx", {1'b0, tx_trig_o}, 8'h10);
        table_sel_i <= 2'h3;
        cyc(3);
        chk_byte("programmable rx", {1'b0, rx_trig_o}, 8'h05);
        chk_byte("programmable tx", {1'b0, tx_trig_o}, 8'h09);
        $display("test receive and triggers done");
        end_sim();
    end
endmodule // uic_core_tb
